/* File: rtl/tsc_regs.svh */
`ifndef TSC_REGS_SVH
`define TSC_REGS_SVH

// Register indices as printed; the APB byte address is four times the index.
`define TSC_IDX_CTRL_PRI      8'h24
`define TSC_IDX_CTRL_SEC      8'h25
`define TSC_IDX_INT_MASK      8'h26
`define TSC_IDX_STATUS        8'h2b
`define TSC_ADDR_CTRL_PRI     12'h090
`define TSC_ADDR_CTRL_SEC     12'h094
`define TSC_ADDR_INT_MASK     12'h098
`define TSC_ADDR_STATUS       12'h0ac

`define TSC_RST_CTRL_PRI      8'h00
`define TSC_RST_CTRL_SEC      8'h00
`define TSC_RST_INT_MASK      8'h08

`define TSC_BIT_FORCE_ACTIVE  6
`define TSC_BIT_CLKSEL_HI     5
`define TSC_BIT_CLKSEL_LO     4
`define TSC_BIT_SENSOR_DIV    3
`define TSC_BIT_UNCOND_CAL    2
`define TSC_BIT_COND_CAL      1
`define TSC_BIT_CAL_HOLD      0

`define TSC_BIT_IRQ_EOC       6
`define TSC_BIT_IRQ_INPUT     5
`define TSC_BIT_IRQ_S2A       2
`define TSC_BIT_IRQ_A2I       1
`define TSC_BIT_IRQ_TOUCH     0
`define TSC_MASK_WRITABLE     8'h67
`define TSC_MASK_CTRL_PRI     8'h7f

`define TSC_SENSOR_DIV_LO     8'd80
`define TSC_SENSOR_DIV_HI     8'd160
// Base system clock divider from sys_clk for the fastest rate; each code doubles it.
`define TSC_SYSCLK_BASE_DIV   8'd125
`define TSC_CAL_CYCLES        16'd1000

`endif

/* File: rtl/tsc_pkg.sv */
package tsc_pkg;
   typedef enum logic [1:0] {CAL_IDLE, CAL_RUN} tsc_cal_e;
   typedef logic [7:0] tsc_byte_t;
endpackage

/* File: rtl/tsc_clk_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface tsc_clk_if;
   logic [1:0] clkSel;
   logic       sensorDiv;
   logic       sysTick;
   logic       sensorTick;
   modport ctl (output clkSel, output sensorDiv, input sysTick, input sensorTick);
   modport gen (input clkSel, input sensorDiv, output sysTick, output sensorTick);
endinterface
`default_nettype wire

/* File: rtl/tsc_clk_gen.sv */
`timescale 1ns/100ps
`default_nettype none
`include "tsc_regs.svh"
module tsc_clk_gen
   import tsc_pkg::*;
(
   // Clock and reset.
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic clkEn,
   // Control and ticks.
   tsc_clk_if.gen    clk
);
   logic [10:0] sysCnt;
   logic [7:0]  senCnt;
   logic [10:0] sysLimit;
   logic [7:0]  senLimit;
   logic        sysWrap;
   logic        senWrap;

   // Each higher select code halves the system clock rate.
   assign sysLimit = ({3'h0, `TSC_SYSCLK_BASE_DIV} << clk.clkSel) - 11'h001; // RULE8
   assign senLimit = (clk.sensorDiv ? `TSC_SENSOR_DIV_HI : `TSC_SENSOR_DIV_LO) - 8'h01; // RULE2
   assign sysWrap  = (sysCnt >= sysLimit);
   assign senWrap  = (senCnt >= senLimit);

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sysCnt <= 11'h000;
         clk.sysTick <= 1'b0;
      end else if (clkEn) begin
         sysCnt <= sysWrap ? 11'h000 : sysCnt + 11'h001;
         clk.sysTick <= sysWrap;
      end
   end

   // The sensor clock counts system clock ticks.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         senCnt <= 8'h00;
         clk.sensorTick <= 1'b0;
      end else if (clkEn) begin
         clk.sensorTick <= 1'b0;
         if (sysWrap) begin
            senCnt <= senWrap ? 8'h00 : senCnt + 8'h01; // RULE2
            clk.sensorTick <= senWrap;
         end
      end
   end
endmodule
`default_nettype wire

/* File: rtl/tsc_ctrl_regs.sv */
// Function
// RULE1 - Force-active bit 6 set keeps device active, never idle or sleep.
// RULE2 - Sensor divide bit 3: 0 gives system clock /80, 1 gives /160.
// RULE3 - Writing 1 to bit 2 calibrates unconditionally; reads 0 when done.
// RULE4 - Writing 1 to bit 1 calibrates only when no touch is sensed.
// RULE5 - Hold bit 0: 0 allows automatic calibration, 1 suppresses it.
// RULE6 - Mask bit 1 blocks its interrupt source; 0 lets it through.
// RULE7 - Mask bits: 6 calibration end, 5 input, 2 wake, 1 idle, 0 touch.
// RULE8 - Clock select bits 5:4: 00 fastest, each higher code halves rate.
`timescale 1ns/100ps
`default_nettype none
`include "tsc_regs.svh"
module tsc_ctrl_regs
   import tsc_pkg::*;
(
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        clkEn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Sensing core status.
   input  wire logic        touchSensed,
   input  wire logic        autoCalRequest,
   input  wire logic        idleRequest,
   input  wire logic [6:0]  rawEvents,
   // Controls to the sensing core.
   output logic             forceActive,
   output logic             lowPowerAllowed,
   output logic             calibrating,
   output logic             sysTick,
   output logic             sensorTick,
   output logic [6:0]       eventEnable,
   output logic [6:0]       maskedEvents,
   output logic             regulatorDisable,
   output logic             sensorClockDisable,
   output logic             beepEnable,
   output logic             irqPolarity
);
   tsc_clk_if clkBus ();
   tsc_byte_t ctrlPri;
   tsc_byte_t ctrlSec;
   tsc_byte_t intMask;
   tsc_cal_e  calState;
   tsc_cal_e  next_calState;
   logic [15:0] calCnt;
   logic [1:0]  touchSync;
   logic        touchNow;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
      hit = (a == b);
   endfunction

   wire access   = psel & penable & clkEn;
   wire wrAccess = access & pwrite & pstrb[0];
   wire selPri   = hit(paddr, `TSC_ADDR_CTRL_PRI);
   wire selSec   = hit(paddr, `TSC_ADDR_CTRL_SEC);
   wire selMask  = hit(paddr, `TSC_ADDR_INT_MASK);
   wire selStat  = hit(paddr, `TSC_ADDR_STATUS);
   wire mapped   = selPri | selSec | selMask | selStat;
   wire wrPri    = wrAccess & selPri;
   wire [7:0] wb = pwdata[7:0];

   // Touch level comes from outside logic, so it is synchronised.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         touchSync <= 2'b00;
      end else if (clkEn) begin
         touchSync <= {touchSync[0], touchSensed};
      end
   end
   assign touchNow = touchSync[1];

   wire startUncond = wrPri & wb[`TSC_BIT_UNCOND_CAL];                       // RULE3
   wire startCond   = wrPri & wb[`TSC_BIT_COND_CAL] & ~touchNow;             // RULE4
   wire startAuto   = autoCalRequest & ~ctrlPri[`TSC_BIT_CAL_HOLD];          // RULE5
   wire calStart    = startUncond | startCond | startAuto;
   wire calDone     = (calState == CAL_RUN) && (calCnt == `TSC_CAL_CYCLES);

   always_comb begin
      next_calState = calState;
      unique case (calState)
         CAL_IDLE: begin
            if (calStart) begin
               next_calState = CAL_RUN;
            end
         end
         CAL_RUN: begin
            // A start that lands on the last cycle runs a fresh calibration, so its request bit stays set for it.
            if (calDone) begin
               next_calState = calStart ? CAL_RUN : CAL_IDLE;
            end
         end
         default: next_calState = CAL_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         calState <= CAL_IDLE;
         calCnt   <= 16'h0000;
      end else if (clkEn) begin
         calState <= next_calState;
         calCnt   <= (calState == CAL_RUN && !calDone) ? calCnt + 16'h0001 : 16'h0000;
      end
   end

   // Calibration request bits stay set until the calibration finishes.
   wire [7:0] priWrite = wb & `TSC_MASK_CTRL_PRI;
   wire [7:0] priNext  = {priWrite[7:3],
                          startUncond | (ctrlPri[`TSC_BIT_UNCOND_CAL] & ~calDone),    // RULE3
                          startCond | (ctrlPri[`TSC_BIT_COND_CAL] & ~calDone),        // RULE4
                          priWrite[0]};
   wire [7:0] priHold  = {ctrlPri[7:3],
                          ctrlPri[`TSC_BIT_UNCOND_CAL] & ~calDone,
                          ctrlPri[`TSC_BIT_COND_CAL] & ~calDone,
                          ctrlPri[0]};

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ctrlPri <= `TSC_RST_CTRL_PRI;
         ctrlSec <= `TSC_RST_CTRL_SEC;
         intMask <= `TSC_RST_INT_MASK;
      end else if (clkEn) begin
         ctrlPri <= wrPri ? priNext : priHold;
         if (wrAccess & selSec) begin
            ctrlSec <= {4'h0, wb[3:0]};
         end
         if (wrAccess & selMask) begin
            intMask <= (wb & `TSC_MASK_WRITABLE) | (intMask & ~`TSC_MASK_WRITABLE); // RULE7
         end
      end
   end

   wire [7:0] statusByte = {5'h00, touchNow, calState == CAL_RUN, forceActive};
   wire [7:0] readByte   = selPri  ? ctrlPri :
                           selSec  ? ctrlSec :
                           selMask ? intMask :
                           selStat ? statusByte : 8'h00;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
      end else if (clkEn && psel && !penable && !pwrite) begin
         prdata <= {24'h000000, readByte};
      end
   end

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   assign forceActive     = ctrlPri[`TSC_BIT_FORCE_ACTIVE];                  // RULE1
   assign lowPowerAllowed = ~forceActive & idleRequest;                       // RULE1
   assign calibrating     = (calState == CAL_RUN);
   assign clkBus.clkSel    = ctrlPri[`TSC_BIT_CLKSEL_HI:`TSC_BIT_CLKSEL_LO];  // RULE8
   assign clkBus.sensorDiv = ctrlPri[`TSC_BIT_SENSOR_DIV];                    // RULE2
   assign sysTick    = clkBus.sysTick;
   assign sensorTick = clkBus.sensorTick;

   genvar i;
   generate
      for (i = 0; i < 7; i++) begin : g_mask
         assign eventEnable[i]  = ~intMask[i];                                // RULE6
         assign maskedEvents[i] = rawEvents[i] & ~intMask[i];                 // RULE6
      end
   endgenerate

   assign regulatorDisable   = ctrlSec[3];
   assign sensorClockDisable = ctrlSec[2];
   assign beepEnable         = ctrlSec[1];
   assign irqPolarity        = ctrlSec[0];

   tsc_clk_gen u_clk_gen (
      .sys_clk (sys_clk),
      .reset   (reset),
      .clkEn   (clkEn),
      .clk     (clkBus.gen)
   );
endmodule
`default_nettype wire

/* File: tb/tsc_ctrl_regs_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module tsc_ctrl_regs_monitor (
   // Clock, reset and APB.
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        clkEn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic        pready,
   // Core side.
   input wire logic        touchSensed,
   input wire logic        autoCalRequest,
   input wire logic        idleRequest,
   input wire logic [6:0]  rawEvents,
   input wire logic        forceActive,
   input wire logic        lowPowerAllowed,
   input wire logic        calibrating,
   input wire logic        sysTick,
   input wire logic [6:0]  eventEnable,
   input wire logic [6:0]  maskedEvents
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   logic [10:0] calCnt;
   wire         wrAcc = psel && penable && pwrite && clkEn && pstrb[0];
   wire         wrPri = wrAcc && paddr == 12'h090;
   wire         wrMsk = wrAcc && paddr == 12'h098;
   // Counts the length of the running calibration.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset)
         calCnt <= '0;
      else
         calCnt <= calibrating ? calCnt + 11'h1 : '0;
   end
   sequence s_touchHeld; touchSensed [*4]; endsequence
   sequence s_condReq; wrPri && pwdata[2:1] == 2'b01 && !calibrating && !autoCalRequest; endsequence
   property p_ready; psel && penable |-> pready; endproperty
   property p_force; wrPri |=> forceActive == $past(pwdata[6]); endproperty
   property p_lowPow; idleRequest |-> lowPowerAllowed == !forceActive; endproperty
   property p_calStart; wrPri && pwdata[2] |=> calibrating; endproperty
   property p_calLen; calibrating |-> calCnt < 11'd1001; endproperty
   property p_cond; s_touchHeld ##0 s_condReq |=> !calibrating; endproperty
   property p_mask; maskedEvents == (rawEvents & eventEnable); endproperty
   property p_resv; eventEnable[4:3] == 2'b10; endproperty
   property p_mskWr; wrMsk |=> eventEnable == ~(($past(pwdata[6:0]) & 7'h67) | 7'h08); endproperty
   property p_sysGap; sysTick |=> !sysTick [*8]; endproperty
   a_ready: assert property (p_ready) else $error("no ready");
   a_force: assert property (p_force) else $error("force bit");
   a_lowPow: assert property (p_lowPow) else $error("low power");
   a_calStart: assert property (p_calStart) else $error("cal start");
   a_calLen: assert property (p_calLen) else $error("cal length");
   a_cond: assert property (p_cond) else $error("cond cal");
   a_mask: assert property (p_mask) else $error("masking");
   a_resv: assert property (p_resv) else $error("reserved");
   a_mskWr: assert property (p_mskWr) else $error("mask write");
   a_sysGap: assert property (p_sysGap) else $error("sys tick");
endmodule
bind tsc_ctrl_regs tsc_ctrl_regs_monitor u_mon (.*);
`default_nettype wire

/* File: tb/test_touch_sensor_control_and_irq_mask.sv */
`timescale 1ns/100ps
`default_nettype none
module test_touch_sensor_control_and_irq_mask;
   logic        sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
   logic        touchSensed = 0, autoCalRequest = 0, idleRequest = 1, err;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [6:0]  rawEvents = 7'h67, eventEnable, maskedEvents;
   logic        pready, pslverr, forceActive, lowPowerAllowed, calibrating, sysTick, sensorTick;
   int          n_errors = 0, n_checks = 0;
   tsc_ctrl_regs u_dut (.sys_clk(sys_clk), .reset(reset), .clkEn(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .touchSensed(touchSensed), .autoCalRequest(autoCalRequest),
      .idleRequest(idleRequest), .rawEvents(rawEvents), .forceActive(forceActive),
      .lowPowerAllowed(lowPowerAllowed), .calibrating(calibrating), .sysTick(sysTick),
      .sensorTick(sensorTick), .eventEnable(eventEnable), .maskedEvents(maskedEvents),
      .regulatorDisable(), .sensorClockDisable(), .beepEnable(), .irqPolarity());
   initial forever #2 sys_clk = ~sys_clk;
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("FAIL %0t got %h exp %h", $time, g, e);
      end
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // One APB transfer; ends one idle cycle after the access phase.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      i = 0;
      do begin
         @(posedge sys_clk);
         i++;
      end while (pready !== 1 && i < 50);
      if (i == 50) begin
         n_errors++;
         end_of_test;
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge sys_clk);
   endtask
   task t_cal(input logic [31:0] d, input logic e);
      int i;
      apb(1, 12'h090, d);
      chk(calibrating, e);
      apb(0, 12'h090, 0);
      chk(rd, e ? d : 0);
      i = 0;
      while (calibrating !== 0 && i < 1100) begin
         @(posedge sys_clk);
         i++;
      end
      if (i == 1100) begin
         n_errors++;
         end_of_test;
      end
      chk(e ? (i >= 990 && i <= 1001) : (i == 0), 1);
      apb(0, 12'h090, 0);
      chk(rd, 0);
   endtask
   task t_auto(input logic h);
      apb(1, 12'h090, {31'h0, h});
      autoCalRequest <= 1;
      @(posedge sys_clk);
      autoCalRequest <= 0;
      @(posedge sys_clk);
      chk(calibrating, !h);
      repeat (1000) @(posedge sys_clk);
   endtask
   // Measures the gap in cycles between two ticks, after skipping the first partial one.
   task t_tick(input logic [31:0] d, input logic s, input int e);
      int i;
      apb(1, 12'h090, d);
      repeat (2) begin
         i = 0;
         do begin
            @(negedge sys_clk);
            i++;
         end while ((s ? sensorTick : sysTick) !== 1 && i < 25000);
      end
      chk(i, e);
      @(posedge sys_clk);
   endtask
   initial begin
      int b[5] = '{0, 1, 2, 5, 6};
      repeat (3) @(posedge sys_clk);
      reset <= 0;
      @(posedge sys_clk);
      apb(0, 12'h098, 0);
      chk(rd, 32'h08);
      chk(eventEnable, 7'h77);
      apb(1, 12'h090, 32'h78);
      apb(0, 12'h090, 0);
      chk(rd, 32'h78);
      chk(lowPowerAllowed, 0);
      apb(1, 12'h090, 0);
      chk(lowPowerAllowed, 1);
      foreach (b[k]) begin
         apb(1, 12'h098, 32'h08 | (32'h1 << b[k]));
         chk(maskedEvents, 7'h67 & ~(7'h1 << b[k]));
      end
      apb(1, 12'h098, 32'hff);
      apb(0, 12'h098, 0);
      chk(rd, 32'h6f);
      apb(1, 12'h098, 32'h08);
      chk(maskedEvents, 7'h67);
      apb(1, 12'h0a0, 32'hff);
      chk(err, 1);
      apb(0, 12'h0a0, 0);
      chk(rd, 0);
      t_cal(32'h4, 1);
      touchSensed <= 1;
      repeat (4) @(posedge sys_clk);
      t_cal(32'h4, 1);
      t_cal(32'h2, 0);
      touchSensed <= 0;
      repeat (4) @(posedge sys_clk);
      t_cal(32'h2, 1);
      t_auto(1);
      t_auto(0);
      t_tick(32'h00, 0, 125);
      t_tick(32'h10, 0, 250);
      t_tick(32'h30, 0, 1000);
      t_tick(32'h00, 1, 10000);
      t_tick(32'h08, 1, 20000);
      end_of_test;
   end
endmodule
`default_nettype wire
